// ===== rtl/sct_timer.sv
// Slow clock interval timer with APB register access
module sct_timer #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_clock_in,
  input wire logic second_pulse_in,
  output logic alarm_wake,
  output logic irq
);
  import sct_pkg::*;

  sct_state_s st_q;
  sct_state_s st_d;
  logic slk_rise;
  logic hz_rise;
  logic roll;
  logic inc;
  logic alm_set;
  logic setup_rd;
  logic wr_acc;
  logic rd_acc;
  logic mode_wr;
  logic restart_wr;
  logic sr_rd;
  logic [15:0] presc_nx;

  // Byte offset within the block, upper address bits must be zero
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [3:0] off);
    reg_hit = (a == ADDR_W'(off));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = reg_hit(a, SCT_OFF_MODE) | reg_hit(a, SCT_OFF_ALARM) |
             reg_hit(a, SCT_OFF_COUNT) | reg_hit(a, SCT_OFF_STATUS);
  endfunction

  //==================================================================
  // Bus decode
  // Read data is captured in the setup cycle so prdata comes from a flop;
  // the access phase then completes with no wait state.
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign mode_wr = wr_acc & reg_hit(paddr, SCT_OFF_MODE);
  assign restart_wr = mode_wr & pwdata[SCT_MODE_RESTART];
  assign sr_rd = rd_acc & reg_hit(paddr, SCT_OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = st_q.prdata;

  //==================================================================
  // Slow clock and 1 Hz edges, taken from the second sync stage only
  assign slk_rise = st_q.slk_sync[1] & ~st_q.slk_prev;
  assign hz_rise = st_q.hz_sync[1] & ~st_q.hz_prev;

  // Prescaler: up count, roll when next value meets the divisor.
  // A divisor of 0 rolls on the 16-bit wrap, i.e. 65536 periods.
  assign presc_nx = st_q.presc + 16'h0001;
  assign roll = ~st_q.dis & slk_rise & (presc_nx == st_q.divisor);

  // Counter source select
  assign inc = st_q.sec_sel ? (~st_q.dis & hz_rise) : roll;
  assign alm_set = inc & (st_q.count == st_q.alarm);

  //==================================================================
  // Next state
  always_comb begin
    st_d = st_q;
    // Two-flop synchronisers for the pins
    // Pins are oversampled on pclk, so a pin pulse must last a few pclk.
    st_d.slk_sync = {st_q.slk_sync[0], slow_clock_in};
    st_d.slk_prev = st_q.slk_sync[1];
    st_d.hz_sync = {st_q.hz_sync[0], second_pulse_in};
    st_d.hz_prev = st_q.hz_sync[1];

    // Disabled timer holds prescaler and counter still
    if (~st_q.dis && slk_rise) begin
      st_d.presc = roll ? 16'h0000 : presc_nx;
    end
    if (inc) begin
      st_d.count = st_q.count + 32'h0000_0001;
    end

    // Flags: a status read clears only what it returned, and a new
    // event in the same cycle wins over the clear
    if (sr_rd) begin
      st_d.tick_flag = st_q.tick_flag & ~st_q.prdata[SCT_STAT_TICK];
      st_d.alm_flag = st_q.alm_flag & ~st_q.prdata[SCT_STAT_ALARM];
    end
    if (roll) begin
      st_d.tick_flag = 1'b1;
    end
    if (alm_set) begin
      st_d.alm_flag = 1'b1;
    end

    // Interrupt hold-off after a status read, counted in slow clocks
    if (sr_rd) begin
      st_d.hold = SCT_IRQ_HOLD;
    end else if (slk_rise && st_q.hold != 2'h0) begin
      st_d.hold = st_q.hold - 2'h1;
    end

    // Register writes
    if (mode_wr) begin
      st_d.divisor = pwdata[SCT_MODE_DIV_LSB +: 16];
      st_d.alm_ie = pwdata[SCT_MODE_ALM_IE];
      st_d.tick_ie = pwdata[SCT_MODE_TICK_IE];
      st_d.dis = pwdata[SCT_MODE_DISABLE];
      st_d.sec_sel = pwdata[SCT_MODE_SEC_SEL];
    end
    // Restart beats any count step in the same cycle
    if (restart_wr) begin
      st_d.presc = 16'h0000;
      st_d.count = 32'h0000_0000;
    end
    if (wr_acc && reg_hit(paddr, SCT_OFF_ALARM)) begin
      st_d.alarm = pwdata;
    end

    // Read capture in the setup cycle; restart bit reads back as zero
    if (setup_rd) begin
      st_d.prdata = 32'h0000_0000;
      if (reg_hit(paddr, SCT_OFF_MODE)) begin
        st_d.prdata[SCT_MODE_DIV_LSB +: 16] = st_q.divisor;
        st_d.prdata[SCT_MODE_ALM_IE] = st_q.alm_ie;
        st_d.prdata[SCT_MODE_TICK_IE] = st_q.tick_ie;
        st_d.prdata[SCT_MODE_DISABLE] = st_q.dis;
        st_d.prdata[SCT_MODE_SEC_SEL] = st_q.sec_sel;
      end else if (reg_hit(paddr, SCT_OFF_ALARM)) begin
        st_d.prdata = st_q.alarm;
      end else if (reg_hit(paddr, SCT_OFF_COUNT)) begin
        st_d.prdata = st_q.count;
      end else if (reg_hit(paddr, SCT_OFF_STATUS)) begin
        st_d.prdata[SCT_STAT_TICK] = st_q.tick_flag;
        st_d.prdata[SCT_STAT_ALARM] = st_q.alm_flag;
      end
    end
  end

  //==================================================================
  // State register; reset loads divisor 0x8000 and alarm all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SCT_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  //==================================================================
  // Outputs: wake follows the alarm flag with no enable gating
  assign alarm_wake = st_q.alm_flag;
  assign irq = (st_q.hold == 2'h0) &
               ((st_q.tick_flag & st_q.tick_ie) |
                (st_q.alm_flag & st_q.alm_ie));

  //==================================================================
  // Checks
  // Step checks leave out restart cycles, since a restart beats any step.
  // Everything here runs on pclk, so one default clocking serves all.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_wake_follows: assert property (
    alm_set |=> alarm_wake)
    else $error("alarm match did not raise wake output");

  chk_irq_cause: assert property (
    irq |-> (st_q.tick_flag && st_q.tick_ie) ||
            (st_q.alm_flag && st_q.alm_ie))
    else $error("interrupt without enabled flag");

  chk_irq_holdoff: assert property (
    sr_rd ##1 !slk_rise |=> !irq)
    else $error("interrupt not held off after status read");

  chk_count_wrap: assert property (
    inc && !restart_wr && st_q.count == 32'hFFFF_FFFF
    |=> st_q.count == 32'h0000_0000)
    else $error("counter did not wrap to zero");

  chk_alarm_plus: assert property (
    $rose(st_q.alm_flag) && !$past(restart_wr)
    |-> st_q.count == st_q.alarm + 32'h0000_0001)
    else $error("alarm flag without count at alarm plus one");

  chk_restart_zero: assert property (
    restart_wr |=> st_q.count == 32'h0000_0000 &&
                   st_q.presc == 16'h0000)
    else $error("restart did not clear prescaler and counter");

  chk_disable_frozen: assert property (
    st_q.dis && !mode_wr |=> $stable(st_q.count) && $stable(st_q.presc))
    else $error("disabled timer still switching");

  chk_tick_sets: assert property (
    roll |=> st_q.tick_flag)
    else $error("roll-over did not set tick flag");

  chk_second_mode: assert property (
    st_q.sec_sel && !hz_rise && !restart_wr |=> $stable(st_q.count))
    else $error("counter moved without 1 Hz pulse");

  chk_status_clear: assert property (
    sr_rd && !roll && !alm_set && st_q.prdata[SCT_STAT_TICK] &&
    st_q.prdata[SCT_STAT_ALARM] |=> !st_q.tick_flag && !st_q.alm_flag)
    else $error("status read did not clear flags");

  // Interrupt path and hold-off after a status read
  chk_tick_irq: assert property (
    st_q.hold == 2'h0 && st_q.tick_flag && st_q.tick_ie |-> irq)
    else $error("enabled tick flag did not raise interrupt");

  chk_alarm_irq: assert property (
    st_q.hold == 2'h0 && st_q.alm_flag && st_q.alm_ie |-> irq)
    else $error("enabled alarm flag did not raise interrupt");

  chk_irq_held: assert property (
    st_q.hold != 2'h0 |-> !irq)
    else $error("interrupt raised during hold-off");

  chk_hold_load: assert property (
    sr_rd |=> st_q.hold == SCT_IRQ_HOLD)
    else $error("status read did not start hold-off");

  chk_hold_step: assert property (
    !sr_rd && slk_rise && st_q.hold != 2'h0
    |=> st_q.hold == $past(st_q.hold) - 2'h1)
    else $error("hold-off did not count slow clock edges");

  chk_hold_idle: assert property (
    !sr_rd && !slk_rise |=> $stable(st_q.hold))
    else $error("hold-off moved without slow clock edge");

  // Prescaler: one step per slow edge, roll at the divisor
  chk_presc_step: assert property (
    !st_q.dis && slk_rise && !roll && !restart_wr
    |=> st_q.presc == $past(st_q.presc) + 16'h0001)
    else $error("prescaler did not step on slow clock edge");

  chk_presc_idle: assert property (
    !slk_rise && !restart_wr |=> $stable(st_q.presc))
    else $error("prescaler moved without slow clock edge");

  chk_presc_roll: assert property (
    roll && !restart_wr |=> st_q.presc == 16'h0000)
    else $error("prescaler did not return to zero on roll");

  chk_roll_point: assert property (
    roll |-> (st_q.divisor == 16'h0000 && st_q.presc == 16'hFFFF) ||
             (st_q.divisor != 16'h0000 &&
              st_q.presc == st_q.divisor - 16'h0001))
    else $error("roll-over at wrong prescaler value");

  // Counter source and step
  chk_count_step: assert property (
    !st_q.sec_sel && roll && !restart_wr
    |=> st_q.count == $past(st_q.count) + 32'h0000_0001)
    else $error("roll-over did not step the counter");

  chk_count_idle: assert property (
    !st_q.sec_sel && !roll && !restart_wr |=> $stable(st_q.count))
    else $error("counter moved without roll-over");

  chk_second_step: assert property (
    st_q.sec_sel && !st_q.dis && hz_rise && !restart_wr
    |=> st_q.count == $past(st_q.count) + 32'h0000_0001)
    else $error("1 Hz pulse did not step the counter");

  chk_disable_idle: assert property (
    st_q.dis |-> !roll && !inc)
    else $error("disabled timer produced a count event");

  // Flags move only on their own event or a status read
  chk_alarm_sets: assert property (
    alm_set |=> st_q.alm_flag)
    else $error("alarm match did not set alarm flag");

  chk_tick_second: assert property (
    st_q.sec_sel && roll |=> st_q.tick_flag)
    else $error("roll-over in 1 Hz mode did not set tick flag");

  chk_tick_cause: assert property (
    !roll |=> !$rose(st_q.tick_flag))
    else $error("tick flag set without roll-over");

  chk_alarm_cause: assert property (
    !alm_set |=> !$rose(st_q.alm_flag))
    else $error("alarm flag set without match");

  chk_flag_keep: assert property (
    !sr_rd |=> !$fell(st_q.tick_flag) && !$fell(st_q.alm_flag))
    else $error("flag cleared without status read");

endmodule // sct_timer

// ===== rtl/sct_pkg.sv
// Package: constants, state layout and reset values of the interval timer
//==================================================================
package sct_pkg;

  //==================================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] SCT_OFF_MODE = 4'h0; // timer_mode_reg
  localparam logic [3:0] SCT_OFF_ALARM = 4'h4; // alarm_value_reg
  localparam logic [3:0] SCT_OFF_COUNT = 4'h8; // current_count_reg
  localparam logic [3:0] SCT_OFF_STATUS = 4'hC; // timer_status_reg

  //==================================================================
  // Mode register fields
  localparam int SCT_MODE_DIV_LSB = 0;
  localparam int SCT_MODE_ALM_IE = 16;
  localparam int SCT_MODE_TICK_IE = 17;
  localparam int SCT_MODE_RESTART = 18;
  localparam int SCT_MODE_DISABLE = 20;
  localparam int SCT_MODE_SEC_SEL = 24;
  // Status register fields
  localparam int SCT_STAT_ALARM = 0;
  localparam int SCT_STAT_TICK = 1;

  //==================================================================
  // Reset values and timing
  localparam logic [15:0] SCT_DIV_RST = 16'h8000;
  localparam logic [31:0] SCT_ALARM_RST = 32'hFFFF_FFFF;
  localparam logic [1:0] SCT_IRQ_HOLD = 2'h2; // slow clock cycles

  //==================================================================
  // Whole state of the timer, registered as one word
  typedef struct packed {
    logic [1:0] slk_sync;
    logic slk_prev;
    logic [1:0] hz_sync;
    logic hz_prev;
    logic [15:0] presc;
    logic [31:0] count;
    logic [31:0] alarm;
    logic [15:0] divisor;
    logic alm_ie;
    logic tick_ie;
    logic dis;
    logic sec_sel;
    logic tick_flag;
    logic alm_flag;
    logic [1:0] hold;
    logic [31:0] prdata;
  } sct_state_s;

  localparam sct_state_s SCT_STATE_RST = '{
    divisor: SCT_DIV_RST,
    alarm: SCT_ALARM_RST,
    default: '0
  };

endpackage

// ===== sim/sct_timer_tb.sv
// Self-checking testbench of the slow clock interval timer
module sct_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sct_pkg::*;

  //==================================================================
  // Stimulus, design outputs and reference model state
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'h0;
  logic hz = 1'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic alarm_wake;
  logic irq;
  logic er;
  logic xi;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 41862;
  int presc = 0;
  int hold = 0;
  int k;
  logic [31:0] cnt = 32'h0;
  logic [31:0] alm_v = 32'hFFFF_FFFF;
  logic [31:0] rd;
  logic [15:0] div = 16'h8000;
  logic aie = 1'h0, tie = 1'h0, dis = 1'h0, sel = 1'h0;
  logic tick = 1'h0, alm = 1'h0;

  // Bus clock, 40 MHz
  always #12.5 pclk = ~pclk;

  sct_timer sct_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_clock_in(slow), .second_pulse_in(hz),
    .alarm_wake(alarm_wake), .irq(irq));

  //==================================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdchk(input string n, input logic [3:0] o,
                       input logic [31:0] e);
    apb(1'h0, {8'h0, o}, 32'h0);
    chk(n, e, rd);
  endtask

  // Status read clears flags and starts the two slow edge hold-off
  task automatic stat;
    rdchk("status", SCT_OFF_STATUS, {30'h0, tick, alm});
    tick = 1'h0;
    alm = 1'h0;
    hold = 2;
  endtask

  task automatic step;
    if (cnt == alm_v) alm = 1'h1;
    cnt++;
  endtask

  task automatic mode(input logic [15:0] d, input logic a, t, r, s, x);
    logic [31:0] w;
    w = {7'h0, x, 3'h0, s, 1'h0, r, t, a, d};
    apb(1'h1, {8'h0, SCT_OFF_MODE}, w);
    {div, aie, tie, dis, sel} = {d, a, t, s, x};
    if (r) begin
      presc = 0;
      cnt = 32'h0;
    end
    rdchk("mode", SCT_OFF_MODE, w & ~32'h0004_0000);
  endtask

  // Pulses on the slow clock (h=0) or the 1 Hz line (h=1)
  task automatic pulse(input int n, input logic h);
    repeat (n) begin
      @(posedge pclk);
      if (h) hz <= 1'h1;
      else slow <= 1'h1;
      repeat (8) @(posedge pclk);
      hz <= 1'h0;
      slow <= 1'h0;
      repeat (8) @(posedge pclk);
      if (h) begin
        if (!dis && sel) step();
      end else begin
        if (hold > 0) hold--;
        if (!dis) presc++;
        if (presc == (div == 16'h0 ? 65536 : int'(div))) begin
          presc = 0;
          tick = 1'h1;
          if (!sel) step();
        end
      end
      chk("wake", {31'h0, alm}, {31'h0, alarm_wake});
      xi = hold == 0 && (tick && tie || alm && aie);
      chk("irq", {31'h0, xi}, {31'h0, irq});
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  //==================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rdchk("mode", SCT_OFF_MODE, 32'h0000_8000);
    rdchk("alarm", SCT_OFF_ALARM, 32'hFFFF_FFFF);
    stat();
    apb(1'h0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("unmapped", 32'h0, rd);
    apb(1'h1, {8'h0, SCT_OFF_COUNT}, 32'h0000_0055);
    chk("slverr", 32'h0, {31'h0, er});
    rdchk("count", SCT_OFF_COUNT, cnt);
    // Random divisors, each restarted from zero, tick enable kept clear
    repeat (3) begin
      k = 3 + ($random(seed) & 7);
      mode(16'(k), 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
      pulse(int'(div) * 2 + 1, 1'h0);
      rdchk("count", SCT_OFF_COUNT, cnt);
      stat();
      stat();
    end
    // Alarm with its enable cleared while the value is written
    mode(16'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    alm_v = 32'(2 + ($random(seed) & 3));
    apb(1'h1, {8'h0, SCT_OFF_ALARM}, alm_v);
    rdchk("alarm", SCT_OFF_ALARM, alm_v);
    mode(16'h3, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    pulse(3 * int'(alm_v) + 3, 1'h0);
    rdchk("count", SCT_OFF_COUNT, alm_v + 32'h1);
    stat();
    // Tick interrupt held off for two slow edges after a status read
    // Handler style: enable off, read, enable back; next roll is held off
    mode(16'h3, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    pulse(5, 1'h0);
    mode(16'h3, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    stat();
    mode(16'h3, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    pulse(6, 1'h0);
    // Second source drives the counter, prescaler still ticks
    k = 1 + ($random(seed) & 3);
    mode(16'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
    pulse(k, 1'h1);
    pulse(4, 1'h0);
    rdchk("count", SCT_OFF_COUNT, cnt);
    stat();
    // Disabled timer ignores both sources
    mode(16'h3, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    pulse(2, 1'h1);
    pulse(7, 1'h0);
    rdchk("count", SCT_OFF_COUNT, cnt);
    rdchk("count", SCT_OFF_COUNT, cnt);
    stat();
    summarize();
  end

  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (80000) @(posedge pclk);
    fail_count++;
    summarize();
  end

endmodule // sct_timer_tb
